// File: sfds_params.svh
// Purpose: constants of the serial port fifo data and status block
// Assumes: 16-bit register data, byte addresses on a plain register port
// Notes: definitions only
`ifndef SFDS_PARAMS_SVH
`define SFDS_PARAMS_SVH

`define SFDS_DATA_W 16
`define SFDS_ADDR_W 8
`define SFDS_FIFO_DEPTH 8
`define SFDS_PTR_W 3

`define SFDS_OFF_DATA 8'h00
`define SFDS_OFF_STATUS 8'h04
`define SFDS_OFF_CTRL 8'h08
`define SFDS_OFF_INT_STATUS 8'h0c
`define SFDS_OFF_INT_MASK 8'h10

`define SFDS_ST_TX_EMPTY 0
`define SFDS_ST_TX_NOT_FULL 1
`define SFDS_ST_RX_NOT_EMPTY 2
`define SFDS_ST_RX_FULL 3
`define SFDS_ST_BUSY 4

`define SFDS_CTRL_SIZE_LSB 0
`define SFDS_CTRL_SIZE_MSB 3
`define SFDS_CTRL_EN 4
`define SFDS_CTRL_RESET 5'h0f
`define SFDS_SIZE_MIN 4'h3

`define SFDS_INT_OVERRUN 0
`define SFDS_INT_RX_WORD 1
`define SFDS_INT_UNDERRUN 2
`define SFDS_INT_W 3

`endif

// File: sfds_pkg.sv
// Purpose: types of the serial port fifo data and status block
// Assumes: nothing
// Notes: link phase states
package sfds_pkg;
    typedef enum logic [1:0] {
        SFDS_IDLE,
        SFDS_FRAME
    } sfds_link_e;
endpackage

// File: sfds_fifo.sv
// Purpose: synchronous fifo with read and write pointers
// Assumes: one clock, synchronous active high reset
// Notes: rd_data shows the entry at the read pointer
`timescale 1ns/1ps
`include "sfds_params.svh"

module sfds_fifo
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [`SFDS_DATA_W-1:0] wr_data,
    input wire logic rd_en,
    output logic [`SFDS_DATA_W-1:0] rd_data,
    output logic empty,
    output logic full
);
    logic [`SFDS_DATA_W-1:0] mem [0:`SFDS_FIFO_DEPTH-1];
    logic [`SFDS_PTR_W-1:0] wr_ptr;
    logic [`SFDS_PTR_W-1:0] rd_ptr;
    logic [`SFDS_PTR_W:0] count;
    logic do_wr;
    logic do_rd;

    // a blocked access leaves the pointers alone
    assign do_wr = wr_en && !full;
    assign do_rd = rd_en && !empty;
    assign empty = (count == '0);
    assign full = (count == (`SFDS_PTR_W+1)'(`SFDS_FIFO_DEPTH));
    assign rd_data = mem[rd_ptr];

    always_ff @(posedge mclk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= wr_data;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd)
            begin
                count <= count + 1'b1;
            end
            else if (do_rd && !do_wr)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// File: sfds_top.sv
// Purpose: software data and status path of a synchronous serial port, slave on the link
// Assumes: link clock, select and data come from the peer and are synchronised here
// Notes: frame size is control bits 3:0 plus one, 4 to 16 bits, msb first
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "sfds_params.svh"

module sfds_top
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [`SFDS_ADDR_W-1:0] reg_addr,
    input wire logic [`SFDS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`SFDS_DATA_W-1:0] reg_rdata,
    input wire logic link_clk,
    input wire logic link_sel_n,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_en,
    output logic irq
);
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic clk_d;
    logic clk_rise;
    logic clk_fall;
    logic sel_act;
    logic [4:0] ctrl;
    logic [`SFDS_INT_W-1:0] int_status;
    logic [`SFDS_INT_W-1:0] int_mask;
    logic [`SFDS_INT_W-1:0] int_event;
    sfds_pkg::sfds_link_e link_state;
    logic [3:0] size_m1;
    logic [3:0] bit_cnt;
    logic [`SFDS_DATA_W-1:0] tx_sh;
    logic [`SFDS_DATA_W-1:0] rx_sh;
    logic reload;
    logic load_now;
    logic word_done;
    logic [`SFDS_DATA_W-1:0] rx_word;
    logic tx_empty;
    logic tx_full;
    logic rx_empty;
    logic rx_full;
    logic [`SFDS_DATA_W-1:0] tx_head;
    logic [`SFDS_DATA_W-1:0] rx_head;
    logic [`SFDS_DATA_W-1:0] status;
    logic data_wr;
    logic data_rd;
    logic [`SFDS_DATA_W-1:0] next_rdata;

    function automatic logic [`SFDS_DATA_W-1:0] size_mask(input logic [3:0] m1);
        size_mask = 16'hffff >> (4'hf - m1);
    endfunction

    // two-stage synchronisers for clock, select and data
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end
                else
                begin
                    sync1[gi] <= (gi == 0) ? link_clk : ((gi == 1) ? !link_sel_n : serial_in_pin);
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            clk_d <= 1'b0;
        end
        else
        begin
            clk_d <= sync2[0];
        end
    end

    assign clk_rise = sync2[0] && !clk_d;
    assign clk_fall = !sync2[0] && clk_d;
    assign sel_act = sync2[1] && ctrl[`SFDS_CTRL_EN];
    assign size_m1 = (ctrl[`SFDS_CTRL_SIZE_MSB:`SFDS_CTRL_SIZE_LSB] < `SFDS_SIZE_MIN) ?
                     `SFDS_SIZE_MIN : ctrl[`SFDS_CTRL_SIZE_MSB:`SFDS_CTRL_SIZE_LSB];

    // register port decode
    assign data_wr = reg_wr && (reg_addr == `SFDS_OFF_DATA);
    assign data_rd = reg_rd && (reg_addr == `SFDS_OFF_DATA);

    // status word, upper bits read zero
    always_comb
    begin
        status = '0;
        status[`SFDS_ST_BUSY] = (link_state == sfds_pkg::SFDS_FRAME) || !tx_empty;
        status[`SFDS_ST_RX_FULL] = rx_full;
        status[`SFDS_ST_RX_NOT_EMPTY] = !rx_empty;
        status[`SFDS_ST_TX_NOT_FULL] = !tx_full;
        status[`SFDS_ST_TX_EMPTY] = tx_empty;
    end

    always_comb
    begin
        case (reg_addr)
            `SFDS_OFF_DATA: next_rdata = rx_head;
            `SFDS_OFF_STATUS: next_rdata = status;
            `SFDS_OFF_CTRL: next_rdata = {11'h000, ctrl};
            `SFDS_OFF_INT_STATUS: next_rdata = {13'h0, int_status};
            `SFDS_OFF_INT_MASK: next_rdata = {13'h0, int_mask};
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_rd)
        begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ctrl <= `SFDS_CTRL_RESET;
            int_mask <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `SFDS_OFF_CTRL)
            begin
                ctrl <= reg_wdata[4:0];
            end
            if (reg_addr == `SFDS_OFF_INT_MASK)
            begin
                int_mask <= reg_wdata[`SFDS_INT_W-1:0];
            end
        end
    end

    // link frame tracking
    assign load_now = (sel_act && link_state == sfds_pkg::SFDS_IDLE) || (sel_act && clk_fall && reload);
    assign word_done = sel_act && clk_rise && (bit_cnt == size_m1);
    // short received words are right justified with zero upper bits
    assign rx_word = {rx_sh[14:0], sync2[2]} & size_mask(size_m1);

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            link_state <= sfds_pkg::SFDS_IDLE;
            bit_cnt <= 4'h0;
            reload <= 1'b0;
            rx_sh <= 16'h0000;
        end
        else
        begin
            case (link_state)
                sfds_pkg::SFDS_IDLE:
                begin
                    bit_cnt <= 4'h0;
                    reload <= 1'b0;
                    if (sel_act)
                    begin
                        link_state <= sfds_pkg::SFDS_FRAME;
                    end
                end
                sfds_pkg::SFDS_FRAME:
                begin
                    if (!sel_act)
                    begin
                        link_state <= sfds_pkg::SFDS_IDLE;
                    end
                    else
                    begin
                        if (clk_rise)
                        begin
                            rx_sh <= {rx_sh[14:0], sync2[2]};
                            bit_cnt <= word_done ? 4'h0 : bit_cnt + 4'h1;
                        end
                        if (word_done)
                        begin
                            reload <= 1'b1;
                        end
                        else if (clk_fall)
                        begin
                            reload <= 1'b0;
                        end
                    end
                end
                default: link_state <= sfds_pkg::SFDS_IDLE;
            endcase
        end
    end

    // transmit shifter, word aligned to bit 15 so unused upper bits never leave
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            tx_sh <= 16'h0000;
        end
        else if (load_now)
        begin
            tx_sh <= tx_empty ? 16'h0000 : (tx_head << (4'hf - size_m1));
        end
        else if (sel_act && clk_fall)
        begin
            tx_sh <= {tx_sh[14:0], 1'b0};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            serial_out_pin <= 1'b0;
            serial_out_en <= 1'b0;
        end
        else
        begin
            serial_out_pin <= tx_sh[15];
            serial_out_en <= sel_act && link_state == sfds_pkg::SFDS_FRAME;
        end
    end

    // interrupt events: overrun, word received, transmit underrun
    always_comb
    begin
        int_event = '0;
        int_event[`SFDS_INT_OVERRUN] = word_done && rx_full;
        int_event[`SFDS_INT_RX_WORD] = word_done;
        int_event[`SFDS_INT_UNDERRUN] = load_now && tx_empty;
    end

    // write one clears, a new event wins over the clear
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            int_status <= '0;
        end
        else
        begin
            int_status <= (int_status & ~((reg_wr && reg_addr == `SFDS_OFF_INT_STATUS) ?
                          reg_wdata[`SFDS_INT_W-1:0] : {`SFDS_INT_W{1'b0}})) | int_event;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(int_status & int_mask);
        end
    end

    sfds_fifo u_tx_fifo
    (
        .mclk(mclk),
        .reset(reset),
        .wr_en(data_wr),
        .wr_data(reg_wdata),
        .rd_en(load_now),
        .rd_data(tx_head),
        .empty(tx_empty),
        .full(tx_full)
    );

    sfds_fifo u_rx_fifo
    (
        .mclk(mclk),
        .reset(reset),
        .wr_en(word_done),
        .wr_data(rx_word),
        .rd_en(data_rd),
        .rd_data(rx_head),
        .empty(rx_empty),
        .full(rx_full)
    );
endmodule

// File: sfds_monitor.sv
// Purpose: port checks of the fifo data and status block
// Assumes: bound to sfds_top
// Notes: 0x14 is unmapped
`timescale 1ns/1ps
`include "sfds_params.svh"
module sfds_monitor
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [`SFDS_ADDR_W-1:0] reg_addr,
    input wire logic [`SFDS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`SFDS_DATA_W-1:0] reg_rdata,
    input wire logic link_clk,
    input wire logic link_sel_n,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic serial_out_en,
    input wire logic irq
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (reset);
    sequence s_st;
        reg_rd && reg_addr == 8'h04;
    endsequence
    sequence s_push;
        link_sel_n [*4] ##0 (reg_wr && reg_addr == 8'h00);
    endsequence
    property p_hi; s_st |=> reg_rdata[15:5] == 11'h000; endproperty
    a_hi: assert property (p_hi) else $error("status high bits set");
    property p_full; s_st |=> !(reg_rdata[3] && !reg_rdata[2]); endproperty
    a_full: assert property (p_full) else $error("rx full but empty");
    property p_room; s_st |=> !(reg_rdata[0] && !reg_rdata[1]); endproperty
    a_room: assert property (p_room) else $error("tx empty but full");
    property p_push; s_push ##2 s_st |=> !reg_rdata[0] && reg_rdata[4]; endproperty
    a_push: assert property (p_push) else $error("push not in status");
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unm; reg_rd && reg_addr == 8'h14 |=> reg_rdata == 16'h0000; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_idle; link_sel_n [*4] |=> !serial_out_en; endproperty
    a_idle: assert property (p_idle) else $error("driving while idle");
    property p_en; $rose(serial_out_en) |-> $past(!link_sel_n, 3); endproperty
    a_en: assert property (p_en) else $error("drive without select");
endmodule
bind sfds_top sfds_monitor u_mon (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk), .link_sel_n(link_sel_n),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_en(serial_out_en), .irq(irq));

// File: sfds_peer.sv
// Purpose: link master model facing the block
// Assumes: clock idles low, data changes at fall
// Notes: select rises before the last fall so no further word loads
`timescale 1ns/1ps
module sfds_peer
#(
    parameter int half_ns = 200
)
(
    output logic link_clk,
    output logic link_sel_n,
    output logic serial_in_pin,
    input wire logic serial_out_pin
);
    initial
    begin
        link_clk = 1'b0;
        link_sel_n = 1'b1;
        serial_in_pin = 1'b0;
    end
    task automatic frame(input int n, input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        link_sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in_pin = tx[i];
            #(half_ns);
            link_clk = 1'b1;
            #(half_ns);
            rx = {rx[14:0], serial_out_pin};
            if (i == 0)
            begin
                link_sel_n = 1'b1;
                #(half_ns / 2);
            end
            link_clk = 1'b0;
        end
        serial_in_pin = ~serial_in_pin;
        #(half_ns);
    endtask
endmodule

// File: serial_port_fifo_data_status_tb.sv
// Purpose: self-checking bench of the fifo data and status block
// Assumes: 20 MHz mclk, peer half period 200 ns
// Notes: frames of 8 and 4 bits
`timescale 1ns/1ps
`include "sfds_params.svh"
module serial_port_fifo_data_status_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [`SFDS_ADDR_W-1:0] reg_addr = 8'h00;
    logic [`SFDS_DATA_W-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [`SFDS_DATA_W-1:0] reg_rdata;
    logic link_clk, link_sel_n, serial_in_pin, serial_out_pin, serial_out_en, irq;
    logic [15:0] got;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #25 mclk = ~mclk;
    sfds_top dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk), .link_sel_n(link_sel_n),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_en(serial_out_en), .irq(irq));
    // an undriven line reads inverted, so the peer only sees data while the block drives
    sfds_peer peer (.link_clk(link_clk), .link_sel_n(link_sel_n), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_en ? serial_out_pin : ~serial_out_pin));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(what, reg_rdata, exp);
    endtask
    task automatic irq_is(input logic exp);
        @(posedge mclk);
        #1;
        check("irq", {15'h0000, irq}, {15'h0000, exp});
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        rd(8'h04, 16'h0003, "status reset");
        wr(8'h04, 16'h0000);
        rd(8'h14, 16'h0000, "unmapped");
        wr(8'h08, 16'h0017);
        wr(8'h10, 16'h0002);
        for (int i = 0; i < 9; i++)
        begin
            wr(8'h00, 16'ha530 + 16'(i));
            rd(8'h04, (i < 7) ? 16'h0012 : 16'h0010, "status fill");
        end
        for (int i = 0; i < 9; i++)
        begin
            #13;
            peer.frame(8, 16'h00c0 + 16'(i), got);
            check("tx word", got, (i < 8) ? 16'h0030 + 16'(i) : 16'h0000);
        end
        rd(8'h04, 16'h000f, "status full");
        irq_is(1'b1);
        rd(8'h0c, 16'h0007, "events");
        wr(8'h10, 16'h0000);
        irq_is(1'b0);
        wr(8'h10, 16'h0005);
        rd(8'h10, 16'h0005, "mask");
        irq_is(1'b1);
        wr(8'h0c, 16'h0007);
        irq_is(1'b0);
        rd(8'h0c, 16'h0000, "events cleared");
        for (int i = 0; i < 8; i++)
            rd(8'h00, 16'h00c0 + 16'(i), "rx word");
        @(posedge mclk);
        reg_addr <= 8'h00;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        rd(8'h04, 16'h0003, "status drained");
        wr(8'h08, 16'h0013);
        wr(8'h00, 16'hfff5);
        #13;
        peer.frame(4, 16'h000a, got);
        check("short tx", got, 16'h0005);
        rd(8'h00, 16'h000a, "short rx");
        wr(8'h08, 16'h0011);
        rd(8'h08, 16'h0011, "ctrl");
        wr(8'h00, 16'h0003);
        #13;
        peer.frame(4, 16'h0006, got);
        check("clamped tx", got, 16'h0003);
        rd(8'h00, 16'h0006, "clamped rx");
        summarize();
    end
endmodule
